// ---- core/tdc_params.svh ----
`ifndef TDC_PARAMS_SVH
`define TDC_PARAMS_SVH
// Register indices, byte address is four times the index
`define TDC_IDX_MON_FILL 6'h30
`define TDC_IDX_CNT_FRAME 6'h31
`define TDC_IDX_PRELOAD_LOW 6'h32
// Monitor and fill control fields
`define TDC_F_A_SEL 7:6
`define TDC_F_B_SEL 5:4
`define TDC_F_FILL_EN 3
`define TDC_F_PATTERN 2:1
`define TDC_F_DONE 0
// Counter and frame control fields
`define TDC_F_FREE_CYCLE 7
`define TDC_F_CARRY_BREAK 6
`define TDC_F_EXT_FRAME 5
`define TDC_F_PRELOAD_EN 3:2
`define TDC_F_PRELOAD_HIGH 1:0
`define TDC_CNT_FRAME_MASK 8'hef
// Reset values
`define TDC_RST_MON_FILL 8'h00
`define TDC_RST_CNT_FRAME 8'h00
`define TDC_RST_PRELOAD_LOW 8'h00
// Fill space: data locations first, then content-addressable ones
`define TDC_DATA_LOCS 11'h400
`define TDC_CAM_LOCS 11'h200
`define TDC_FILL_LAST 11'h5ff
// Fill patterns
`define TDC_CHECK_A 8'h55
`define TDC_CHECK_B 8'haa
`endif

// ---- core/tdc_pkg.sv ----
package tdc_pkg;
  typedef enum logic [1:0] {PIN_NORMAL, PIN_COUNTER, PIN_MEMSTAT, PIN_ERRORS} tdc_pin_sel_t;
  typedef enum logic [1:0] {PAT_CHECK0, PAT_CHECK1, PAT_ADDR, PAT_INV} tdc_pattern_t;
  typedef enum logic {FILL_IDLE, FILL_RUN} tdc_fill_st_t;
  typedef struct packed {
    logic [7:0]   mon_fill_r;
    logic [7:0]   cnt_frame_r;
    logic [7:0]   preload_low_r;
    logic         ack_r;
    logic [7:0]   rdata_r;
    tdc_fill_st_t fill_st_r;
    logic [10:0]  fill_ptr_r;
    logic         fill_we_r;
    logic [10:0]  fill_addr_r;
    logic [7:0]   fill_data_r;
    logic         fill_cam_r;
    logic         frame_meta_r;
    logic         frame_sync_r;
    logic         frame_last_r;
    logic [10:0]  cnt_r;
    logic         pre_last_r;
    logic [11:0]  group_a_r;
    logic [11:0]  group_b_r;
    logic         start_a_r;
    logic         start_b_r;
  } tdc_state_t;
endpackage : tdc_pkg

// ---- core/tdc_diag_core.sv ----
// Added by the designer: register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
`include "tdc_params.svh"
module tdc_diag_core (
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic [11:0] normal_group_a,
  input  wire logic [11:0] normal_group_b,
  output logic      [11:0] group_a_pins,
  output logic      [11:0] group_b_pins,
  input  wire logic        even_memory_hit,
  input  wire logic        odd_memory_hit,
  input  wire logic [9:0]  local_data_addr,
  input  wire logic        even_memory_error,
  input  wire logic        odd_memory_error,
  input  wire logic        local_memory_error,
  input  wire logic        overrun_error_flag,
  input  wire logic [5:0]  page_pointers,
  input  wire logic [1:0]  memory_substate,
  input  wire logic [9:0]  local_conn_addr,
  input  wire logic        local_memory_hit,
  input  wire logic [10:0] memory_state_count,
  input  wire logic        frame_internal_n,
  input  wire logic        frame_compensation_pin_n,
  input  wire logic [10:0] group_a_start_addr,
  input  wire logic [10:0] group_b_start_addr,
  output logic      [10:0] state_counter,
  output logic             group_a_start,
  output logic             group_b_start,
  output logic             fill_write,
  output logic      [10:0] fill_addr,
  output logic      [7:0]  fill_data,
  output logic             fill_cam,
  output logic             memory_write_block
);
  import tdc_pkg::*;

  // ==========================================================
  // Helpers
  function automatic logic [7:0] byte_addr(input logic [5:0] idx);
    byte_addr = {idx, 2'b00};
  endfunction : byte_addr

  function automatic logic [7:0] fill_byte(input tdc_pattern_t pat,
                                           input logic [10:0] loc);
    logic       cam;
    logic [7:0] phys;
    cam  = loc >= `TDC_DATA_LOCS;
    phys = cam ? 8'(loc - `TDC_DATA_LOCS) : loc[7:0];
    unique case (pat)
      PAT_CHECK0: fill_byte = loc[0] ? `TDC_CHECK_B : `TDC_CHECK_A;
      PAT_CHECK1: fill_byte = loc[0] ? `TDC_CHECK_A : `TDC_CHECK_B;
      PAT_ADDR:   fill_byte = phys;
      PAT_INV:    fill_byte = ~loc[7:0];
    endcase
  endfunction : fill_byte

  function automatic logic [10:0] split_inc(input logic [10:0] v);
    split_inc = {3'(v[10:8] + 3'h1), 4'(v[7:4] + 4'h1), 4'(v[3:0] + 4'h1)};
  endfunction : split_inc

  // ==========================================================
  // State
  tdc_state_t s_r;
  tdc_state_t s_nxt;

  logic         req;
  logic         take;
  logic         wr_fire;
  logic         hit_mon;
  logic         hit_cnt;
  logic         hit_pre;
  logic         fill_en;
  logic         done_set;
  logic         done_clr;
  logic         pre_en;
  logic         frame_src;
  logic         frame_pulse;
  logic [10:0]  preload_val;
  logic [7:0]   rd_mux;
  tdc_pin_sel_t sel_a;
  tdc_pin_sel_t sel_b;

  assign req     = avs_read | avs_write;
  assign take    = req & s_r.ack_r;
  assign wr_fire = avs_write & take & avs_byteenable[0];
  assign hit_mon = avs_address == byte_addr(`TDC_IDX_MON_FILL);
  assign hit_cnt = avs_address == byte_addr(`TDC_IDX_CNT_FRAME);
  assign hit_pre = avs_address == byte_addr(`TDC_IDX_PRELOAD_LOW);
  assign fill_en = s_r.mon_fill_r[`TDC_F_FILL_EN];
  assign sel_a   = tdc_pin_sel_t'(s_r.mon_fill_r[`TDC_F_A_SEL]);
  assign sel_b   = tdc_pin_sel_t'(s_r.mon_fill_r[`TDC_F_B_SEL]);
  assign pre_en  = |s_r.cnt_frame_r[`TDC_F_PRELOAD_EN];
  assign preload_val = {1'b0, s_r.cnt_frame_r[`TDC_F_PRELOAD_HIGH], s_r.preload_low_r};
  assign frame_src   = s_r.cnt_frame_r[`TDC_F_EXT_FRAME] ? s_r.frame_sync_r
                                                         : frame_internal_n;
  assign frame_pulse = s_r.frame_last_r & ~frame_src;
  assign done_set = (s_r.fill_st_r == FILL_RUN) & fill_en &
                    (s_r.fill_ptr_r == `TDC_FILL_LAST);
  assign done_clr = wr_fire & hit_mon & ~avs_writedata[`TDC_F_DONE];

  always_comb begin
    unique case (1'b1)
      hit_mon: rd_mux = s_r.mon_fill_r;
      hit_cnt: rd_mux = s_r.cnt_frame_r;
      hit_pre: rd_mux = s_r.preload_low_r;
      default: rd_mux = 8'h00;
    endcase
  end

  // ==========================================================
  // Next state
  always_comb begin
    s_nxt = s_r;
    // Bus slave: one wait cycle, then answer
    s_nxt.ack_r = req & ~s_r.ack_r;
    if (req && !s_r.ack_r) begin
      s_nxt.rdata_r = rd_mux;
    end
    if (wr_fire && hit_mon) begin
      s_nxt.mon_fill_r[7:1] = avs_writedata[7:1];
    end
    if (wr_fire && hit_cnt) begin
      s_nxt.cnt_frame_r = avs_writedata[7:0] & `TDC_CNT_FRAME_MASK;
    end
    if (wr_fire && hit_pre) begin
      s_nxt.preload_low_r = avs_writedata[7:0];
    end
    // Done sticky, set wins over clear
    s_nxt.mon_fill_r[`TDC_F_DONE] = done_set |
                                    (s_r.mon_fill_r[`TDC_F_DONE] & ~done_clr);

    // Fill engine
    s_nxt.fill_we_r = 1'b0;
    unique case (s_r.fill_st_r)
      FILL_IDLE: begin
        if (fill_en && !s_r.mon_fill_r[`TDC_F_DONE]) begin
          s_nxt.fill_st_r  = FILL_RUN;
          s_nxt.fill_ptr_r = 11'h000;
        end
      end
      FILL_RUN: begin
        if (!fill_en) begin
          s_nxt.fill_st_r = FILL_IDLE;
        end else begin
          s_nxt.fill_we_r   = 1'b1;
          s_nxt.fill_addr_r = s_r.fill_ptr_r;
          s_nxt.fill_cam_r  = s_r.fill_ptr_r >= `TDC_DATA_LOCS;
          s_nxt.fill_data_r = fill_byte(tdc_pattern_t'(s_r.mon_fill_r[`TDC_F_PATTERN]),
                                        s_r.fill_ptr_r);
          s_nxt.fill_ptr_r  = 11'(s_r.fill_ptr_r + 11'h001);
          if (done_set) begin
            s_nxt.fill_st_r = FILL_IDLE;
          end
        end
      end
    endcase

    s_nxt.frame_meta_r = frame_compensation_pin_n;
    s_nxt.frame_sync_r = s_r.frame_meta_r;
    s_nxt.frame_last_r = frame_src;

    // State counter
    s_nxt.pre_last_r = pre_en;
    if (pre_en) begin
      if (!s_r.pre_last_r || s_r.cnt_r <= 11'h001) begin
        s_nxt.cnt_r = preload_val;
      end else begin
        s_nxt.cnt_r = 11'(s_r.cnt_r - 11'h001);
      end
    end else if (s_r.cnt_frame_r[`TDC_F_CARRY_BREAK]) begin
      s_nxt.cnt_r = split_inc(s_r.cnt_r);
    end else if (frame_pulse && !s_r.cnt_frame_r[`TDC_F_FREE_CYCLE]) begin
      s_nxt.cnt_r = 11'h000;
    end else begin
      s_nxt.cnt_r = 11'(s_r.cnt_r + 11'h001);
    end

    s_nxt.start_a_r = s_r.cnt_r == group_a_start_addr;
    s_nxt.start_b_r = s_r.cnt_r == group_b_start_addr;

    // Group A pin monitor
    unique case (sel_a)
      PIN_NORMAL:  s_nxt.group_a_r = normal_group_a;
      PIN_COUNTER: s_nxt.group_a_r = {1'b0, s_r.cnt_r};
      PIN_MEMSTAT: s_nxt.group_a_r = {even_memory_hit, odd_memory_hit, local_data_addr};
      PIN_ERRORS:  s_nxt.group_a_r = {even_memory_error, odd_memory_error,
                                      local_memory_error, overrun_error_flag,
                                      2'b00, page_pointers};
    endcase
    // Group B pin monitor
    unique case (sel_b)
      PIN_NORMAL:  s_nxt.group_b_r = normal_group_b;
      PIN_COUNTER: s_nxt.group_b_r = {1'b0, s_r.cnt_r};
      PIN_MEMSTAT: s_nxt.group_b_r = {memory_substate, local_conn_addr};
      PIN_ERRORS:  s_nxt.group_b_r = {local_memory_hit, memory_state_count};
    endcase
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================
  // Outputs
  assign avs_waitrequest    = req & ~s_r.ack_r;
  assign avs_readdata       = {24'h000000, s_r.rdata_r};
  assign group_a_pins       = s_r.group_a_r;
  assign group_b_pins       = s_r.group_b_r;
  assign state_counter      = s_r.cnt_r;
  assign group_a_start      = s_r.start_a_r;
  assign group_b_start      = s_r.start_b_r;
  assign fill_write         = s_r.fill_we_r;
  assign fill_addr          = s_r.fill_addr_r;
  assign fill_data          = s_r.fill_data_r;
  assign fill_cam           = s_r.fill_cam_r;
  assign memory_write_block = s_r.mon_fill_r[`TDC_F_DONE];

  // ==========================================================
  // Checks
  property p_a_counter;
    @(posedge clk_sys) disable iff (!reset_n)
    sel_a == PIN_COUNTER |=> group_a_pins == {1'b0, $past(state_counter)};
  endproperty
  a_a_counter: assert property (p_a_counter) else $error("group A counter view wrong");

  property p_b_counter;
    @(posedge clk_sys) disable iff (!reset_n)
    sel_b == PIN_COUNTER |=> group_b_pins == {1'b0, $past(state_counter)};
  endproperty
  a_b_counter: assert property (p_b_counter) else $error("group B counter view wrong");

  property p_a_errors;
    @(posedge clk_sys) disable iff (!reset_n)
    sel_a == PIN_ERRORS |=> group_a_pins[7:6] == 2'b00 &&
                            group_a_pins[5:0] == $past(page_pointers);
  endproperty
  a_a_errors: assert property (p_a_errors) else $error("group A error view wrong");

  property p_b_substate;
    @(posedge clk_sys) disable iff (!reset_n)
    sel_b == PIN_MEMSTAT |=> group_b_pins == {$past(memory_substate), $past(local_conn_addr)};
  endproperty
  a_b_substate: assert property (p_b_substate) else $error("group B substate view wrong");

  property p_done_hold;
    @(posedge clk_sys) disable iff (!reset_n)
    memory_write_block && !done_clr |=> memory_write_block;
  endproperty
  a_done_hold: assert property (p_done_hold) else $error("done status lost");

  property p_no_write_done;
    @(posedge clk_sys) disable iff (!reset_n)
    memory_write_block && $past(memory_write_block) |-> !fill_write;
  endproperty
  a_no_write_done: assert property (p_no_write_done) else $error("write while done");

  property p_done_last;
    @(posedge clk_sys) disable iff (!reset_n)
    $rose(memory_write_block) |-> fill_write && fill_addr == `TDC_FILL_LAST;
  endproperty
  a_done_last: assert property (p_done_last) else $error("done before last location");

  property p_fill_order;
    @(posedge clk_sys) disable iff (!reset_n)
    fill_write && fill_addr != `TDC_FILL_LAST && fill_en ##1 fill_en
      |-> fill_write && fill_addr == 11'($past(fill_addr) + 11'h001);
  endproperty
  a_fill_order: assert property (p_fill_order) else $error("fill not in address order");

  property p_checker;
    @(posedge clk_sys) disable iff (!reset_n)
    fill_write && !fill_cam && $past(s_r.mon_fill_r[`TDC_F_PATTERN]) == 2'b00
      |-> fill_data == (fill_addr[0] ? `TDC_CHECK_B : `TDC_CHECK_A);
  endproperty
  a_checker: assert property (p_checker) else $error("checkerboard pattern wrong");

  property p_split;
    @(posedge clk_sys) disable iff (!reset_n)
    !pre_en && s_r.cnt_frame_r[`TDC_F_CARRY_BREAK]
      |=> state_counter[3:0] == 4'($past(state_counter[3:0]) + 4'h1) &&
          state_counter[10:8] == 3'($past(state_counter[10:8]) + 3'h1);
  endproperty
  a_split: assert property (p_split) else $error("split counter wrong");

  property p_preload;
    @(posedge clk_sys) disable iff (!reset_n)
    pre_en && !s_r.pre_last_r |=> state_counter == $past(preload_val);
  endproperty
  a_preload: assert property (p_preload) else $error("preload not loaded");

  property p_frame;
    @(posedge clk_sys) disable iff (!reset_n)
    frame_pulse && !pre_en && !s_r.cnt_frame_r[`TDC_F_CARRY_BREAK] &&
      !s_r.cnt_frame_r[`TDC_F_FREE_CYCLE] |=> state_counter == 11'h000;
  endproperty
  a_frame: assert property (p_frame) else $error("frame sync missed");

  property p_start;
    @(posedge clk_sys) disable iff (!reset_n)
    state_counter == group_a_start_addr ##1 $stable(group_a_start_addr) |-> group_a_start;
  endproperty
  a_start: assert property (p_start) else $error("group A start missed");

  property p_wait;
    @(posedge clk_sys) disable iff (!reset_n)
    req && avs_waitrequest ##1 req |-> !avs_waitrequest;
  endproperty
  a_wait: assert property (p_wait) else $error("bus answer late");
endmodule : tdc_diag_core
`default_nettype wire

// ---- verification/tdc_diag_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Bench signals
module testbench;
  import tdc_pkg::*;
  localparam logic [7:0] A_MF = 8'hc0;
  localparam logic [7:0] A_CF = 8'hc4;
  localparam logic [7:0] A_PL = 8'hc8;
  logic        clk_sys = 1'b0;
  logic        reset_n = 1'b0;
  logic [7:0]  avs_address = 8'h00;
  logic        avs_read = 1'b0, avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata;
  logic [3:0]  avs_byteenable = 4'h0;
  logic        avs_waitrequest;
  logic [11:0] normal_group_a = 12'h0, normal_group_b = 12'h0, group_a_pins, group_b_pins;
  logic        even_memory_hit = 1'b0, odd_memory_hit = 1'b0, local_memory_hit = 1'b0;
  logic        even_memory_error = 1'b0, odd_memory_error = 1'b0;
  logic        local_memory_error = 1'b0, overrun_error_flag = 1'b0;
  logic [9:0]  local_data_addr = 10'h0, local_conn_addr = 10'h0;
  logic [5:0]  page_pointers = 6'h0;
  logic [1:0]  memory_substate = 2'h0;
  logic [10:0] memory_state_count = 11'h0, state_counter, fill_addr;
  logic        frame_internal_n = 1'b1, frame_compensation_pin_n = 1'b1;
  logic [10:0] group_a_start_addr = 11'h003, group_b_start_addr = 11'h005;
  logic        group_a_start, group_b_start, fill_write, fill_cam, memory_write_block;
  logic [7:0]  fill_data;
  logic [31:0] q;
  logic [1:0]  fill_pat = 2'h0;
  int          fill_idx = 0, miscompares = 0, num_checks = 0, cycles = 0;

  always #10 clk_sys = ~clk_sys;

  tdc_diag_core u_dut (
    .clk_sys(clk_sys), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .normal_group_a(normal_group_a), .normal_group_b(normal_group_b),
    .group_a_pins(group_a_pins), .group_b_pins(group_b_pins),
    .even_memory_hit(even_memory_hit), .odd_memory_hit(odd_memory_hit),
    .local_data_addr(local_data_addr), .even_memory_error(even_memory_error),
    .odd_memory_error(odd_memory_error), .local_memory_error(local_memory_error),
    .overrun_error_flag(overrun_error_flag), .page_pointers(page_pointers),
    .memory_substate(memory_substate), .local_conn_addr(local_conn_addr),
    .local_memory_hit(local_memory_hit), .memory_state_count(memory_state_count),
    .frame_internal_n(frame_internal_n), .frame_compensation_pin_n(frame_compensation_pin_n),
    .group_a_start_addr(group_a_start_addr), .group_b_start_addr(group_b_start_addr),
    .state_counter(state_counter), .group_a_start(group_a_start),
    .group_b_start(group_b_start), .fill_write(fill_write), .fill_addr(fill_addr),
    .fill_data(fill_data), .fill_cam(fill_cam), .memory_write_block(memory_write_block)
  );

  // ==========================================
  // Checking and closing
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic results;
    $display("Checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : results

  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      results();
    end
  end

  // ==========================================
  // Bus access
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d,
                     input logic [3:0] be);
    @(posedge clk_sys);
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_byteenable <= be;
    do begin
      @(negedge clk_sys);
    end while (avs_waitrequest !== 1'b0);
    @(posedge clk_sys);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 4'h1);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00, 4'hf);
    check("readdata", q, {24'h0, exp});
  endtask : rd

  // ==========================================
  // Counter stepping: 0 increment, 1 carry break, 2 preload
  task automatic cnt_run(input int cyc, input int mode, input logic [10:0] n, input int pulse);
    logic [10:0] p, e;
    repeat (3) @(negedge clk_sys);
    p = state_counter;
    for (int i = 0; i < cyc; i++) begin
      @(posedge clk_sys);
      frame_internal_n <= !(i == 2 && pulse == 1);
      frame_compensation_pin_n <= !(i == 2 && pulse == 2);
      @(negedge clk_sys);
      case (mode)
        0: e = p + 11'd1;
        1: e = {p[10:8] + 3'd1, p[7:4] + 4'd1, p[3:0] + 4'd1};
        default: e = (p <= 11'd1) ? n : p - 11'd1;
      endcase
      check("state_counter", state_counter, e);
      check("group_a_start", group_a_start, p == group_a_start_addr);
      check("group_b_start", group_b_start, p == group_b_start_addr);
      p = state_counter;
    end
  endtask : cnt_run

  task automatic pulse_sync(input logic pin);
    logic hit;
    @(posedge clk_sys);
    frame_internal_n <= pin;
    frame_compensation_pin_n <= !pin;
    @(posedge clk_sys);
    frame_internal_n <= 1'b1;
    frame_compensation_pin_n <= 1'b1;
    hit = 1'b0;
    repeat (6) begin
      @(negedge clk_sys);
      if (state_counter === 11'h000) hit = 1'b1;
    end
    check("frame_sync", hit, 1'b1);
  endtask : pulse_sync

  task automatic set_in(input logic [7:0] v);
    @(posedge clk_sys);
    {normal_group_a, normal_group_b} <= {3{v}};
    {even_memory_hit, odd_memory_hit, local_data_addr} <= {v[3:0], v};
    {even_memory_error, odd_memory_error, local_memory_error, overrun_error_flag,
     page_pointers} <= {v[1:0], v};
    {memory_substate, local_conn_addr} <= {v[3:0], v};
    {local_memory_hit, memory_state_count} <= {v[3:0], v};
  endtask : set_in

  function automatic logic [7:0] pat_data(input logic [1:0] p, input logic [10:0] a);
    case (p)
      2'h0: return a[0] ? 8'haa : 8'h55;
      2'h1: return a[0] ? 8'h55 : 8'haa;
      2'h2: return a[7:0];
      default: return ~a[7:0];
    endcase
  endfunction : pat_data

  // Fill monitor: every written location in order
  always @(negedge clk_sys) begin
    if (fill_write === 1'b1) begin
      check("fill_addr", fill_addr, fill_idx[10:0]);
      check("fill_data", fill_data, pat_data(fill_pat, fill_idx[10:0]));
      check("fill_cam", fill_cam, fill_idx >= 1024);
      check("write_block", memory_write_block, fill_idx == 1535);
      fill_idx++;
    end
  end

  // ==========================================
  // Main sequence
  initial begin
    logic [10:0] p;
    logic [11:0] ea, eb;
    repeat (3) @(posedge clk_sys);
    reset_n <= 1'b1;
    rd(A_MF, 8'h00);
    rd(A_CF, 8'h00);
    rd(A_PL, 8'h00);
    wr(8'h10, 8'h33);
    rd(8'h10, 8'h00);
    bus(1'b1, A_PL, 8'h77, 4'h0);
    rd(A_PL, 8'h00);
    wr(A_MF, 8'h01);
    rd(A_MF, 8'h00);
    wr(A_CF, 8'hff);
    rd(A_CF, 8'hef);
    wr(A_CF, 8'h00);
    $display("Test registers done");
    for (int pass = 0; pass < 2; pass++) begin
      set_in(pass == 0 ? 8'h5a : 8'ha5);
      for (int s = 0; s < 4; s++) begin
        wr(A_MF, {s[1:0], s[1:0], 4'h0});
        @(negedge clk_sys);
        p = state_counter;
        @(negedge clk_sys);
        case (s)
          0: {ea, eb} = {normal_group_a, normal_group_b};
          1: {ea, eb} = {1'b0, p, 1'b0, p};
          2: {ea, eb} = {even_memory_hit, odd_memory_hit, local_data_addr,
                         memory_substate, local_conn_addr};
          default: {ea, eb} = {even_memory_error, odd_memory_error, local_memory_error,
                               overrun_error_flag, 2'b00, page_pointers,
                               local_memory_hit, memory_state_count};
        endcase
        check("group_a_pins", group_a_pins, ea);
        check("group_b_pins", group_b_pins, eb);
      end
    end
    wr(A_MF, 8'h00);
    $display("Test pin monitor done");
    pulse_sync(1'b0);
    cnt_run(8, 0, 11'h0, 2);
    wr(A_CF, 8'h80);
    cnt_run(8, 0, 11'h0, 1);
    wr(A_CF, 8'h40);
    cnt_run(20, 1, 11'h0, 0);
    wr(A_CF, 8'h20);
    pulse_sync(1'b1);
    cnt_run(8, 0, 11'h0, 1);
    wr(A_PL, 8'h05);
    wr(A_CF, 8'h04);
    cnt_run(12, 2, 11'h005, 1);
    wr(A_CF, 8'h08);
    cnt_run(8, 2, 11'h005, 0);
    wr(A_PL, 8'h02);
    wr(A_CF, 8'h05);
    cnt_run(6, 2, 11'h102, 0);
    wr(A_CF, 8'h00);
    $display("Test state counter done");
    for (int pt = 0; pt < 4; pt++) begin
      fill_idx = 0;
      fill_pat = pt[1:0];
      wr(A_MF, {4'h0, 1'b1, pt[1:0], 1'b0});
      for (int n = 0; n < 2000 && memory_write_block !== 1'b1; n++) @(negedge clk_sys);
      repeat (5) @(negedge clk_sys);
      check("fill_count", fill_idx, 1536);
      check("fill_write_idle", fill_write, 1'b0);
      rd(A_MF, {4'h0, 1'b1, pt[1:0], 1'b1});
      wr(A_MF, 8'h00);
      rd(A_MF, 8'h00);
      check("write_block_clear", memory_write_block, 1'b0);
    end
    $display("Test memory fill done");
    results();
  end
endmodule : testbench
`default_nettype wire
